// ===== design/quad_flash_descriptor_control.sv
`timescale 1ns/1ps
`default_nettype none
module quad_flash_descriptor_control
    import qfdc_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              ARST_N,
    input  wire logic              CE,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic [2:0]        S_AXI_AWPROT,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    // AXI4-Lite write data
    input  wire logic [DATA_W-1:0] S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic [2:0]        S_AXI_ARPROT,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [DATA_W-1:0]      S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    // FIFO occupancy from the controller core
    input  wire logic [CNT_W-1:0]  TX_FREE_COUNT,
    input  wire logic [CNT_W-1:0]  RX_FILL_COUNT,
    // Descriptor fetch engine
    input  wire logic [DATA_W-1:0] DESC_ADDR,
    input  wire logic              DESC_ADDR_VALID,
    output logic                   FETCH_ENABLE,
    output logic                   POLL_ENABLE,
    output logic                   DMA_ENABLE,
    // Interrupts
    output logic                   TX_INT,
    output logic                   RX_INT,
    output logic                   IRQ
);

    // ********************************************************************
    // Declarations
    // ********************************************************************
    threshold_t        thr_r;                   // Threshold register
    control_t          ctl_r;                   // Descriptor control register
    logic [DATA_W-1:0] cur_addr_r;              // Current descriptor address
    logic [IRQ_W-1:0]  mask_r;                  // Interrupt mask
    logic [IRQ_W-1:0]  status;                  // Sticky status
    logic [IRQ_W-1:0]  events;                  // Flag set events
    logic              tx_hit;                  // Transmit comparison
    logic              rx_hit;                  // Receive comparison
    logic              tx_int_r;
    logic              rx_int_r;
    logic              irq_r;
    logic              desc_load;               // Address accepted this cycle

    logic              awready_r;
    logic              wready_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              arready_r;
    logic              rvalid_r;
    logic [1:0]        rresp_r;
    logic [DATA_W-1:0] rdata_r;
    logic [ADDR_W-1:0] waddr_r;                 // Held write address
    logic [DATA_W-1:0] wdata_r;                 // Held write data
    logic [3:0]        wstrb_r;                 // Held byte strobes
    logic              aw_held_r;
    logic              w_held_r;
    logic              wr_do;                   // Register write this cycle
    logic [DATA_W-1:0] wmask;                   // Byte strobes as a bit mask
    logic [DATA_W-1:0] wbits;                   // Masked write data
    logic              wr_mapped;               // Write address decodes
    logic [DATA_W-1:0] rd_word;                 // Read multiplexer
    logic              rd_mapped;               // Read address decodes
    logic              stat_we;                 // Status clear strobe

    // ********************************************************************
    // Threshold comparators
    // ********************************************************************
    // strictly more space
    level_compare #(.STRICT (1'b1)) u_tx_cmp (
        .count (TX_FREE_COUNT),
        .level (thr_r.tx_space_threshold),
        .hit   (tx_hit)
    );

    level_compare #(.STRICT (1'b0)) u_rx_cmp (
        .count (RX_FILL_COUNT),
        .level (thr_r.rx_fill_threshold),
        .hit   (rx_hit)
    );

    // One flop of latency
    // recompute every cycle that CE is high
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tx_int_r <= 1'b0;
            rx_int_r <= 1'b0;
        end else if (CE) begin
            tx_int_r <= tx_hit;
            rx_int_r <= rx_hit;
        end
    end

    // ********************************************************************
    // Write channel handshakes
    // ********************************************************************
    // Either order; each half held until the write
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            awready_r <= 1'b1;
            aw_held_r <= 1'b0;
            waddr_r   <= '0;
        end else if (CE) begin
            if (S_AXI_AWVALID && awready_r) begin
                // No new address until B completes
                awready_r <= 1'b0;
                aw_held_r <= 1'b1;
                waddr_r   <= S_AXI_AWADDR;
            end else if (wr_do) begin
                aw_held_r <= 1'b0;
            end else if (bvalid_r && S_AXI_BREADY) begin
                awready_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wready_r <= 1'b1;
            w_held_r <= 1'b0;
            wdata_r  <= '0;
            wstrb_r  <= 4'h0;
        end else if (CE) begin
            if (S_AXI_WVALID && wready_r) begin
                wready_r <= 1'b0;
                w_held_r <= 1'b1;
                wdata_r  <= S_AXI_WDATA;
                wstrb_r  <= S_AXI_WSTRB;
            end else if (wr_do) begin
                w_held_r <= 1'b0;
            end else if (bvalid_r && S_AXI_BREADY) begin
                wready_r <= 1'b1;
            end
        end
    end

    // The write happens once both halves are held
    assign wr_do = aw_held_r && w_held_r && !bvalid_r;

    // Byte strobes widened to a bit mask
    assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

    assign wbits = wdata_r & wmask;

    // Decode of the held write address
    always_comb begin
        unique case (waddr_r)
            OFS_THRESHOLD, OFS_CONTROL, OFS_IRQ_STAT, OFS_IRQ_MASK: wr_mapped = 1'b1;
            default:                                                wr_mapped = 1'b0;
        endcase
    end

    // Read-only and unmapped words answer SLVERR
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (CE) begin
            if (wr_do) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && S_AXI_BREADY) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ********************************************************************
    // Software registers
    // ********************************************************************
    // thresholds start at zero; only ten bits stored
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            thr_r.tx_space_threshold <= THR_RESET;
            thr_r.rx_fill_threshold  <= THR_RESET;
        end else if (CE && wr_do && waddr_r == OFS_THRESHOLD) begin
            // Byte 1 holds the transmit field, byte 0 the receive field
            if (wstrb_r[1]) begin
                thr_r.tx_space_threshold <= wbits[THR_TX_LSB +: THR_W];
            end
            if (wstrb_r[0]) begin
                thr_r.rx_fill_threshold <= wbits[THR_RX_LSB +: THR_W];
            end
        end
    end

    // Control register; only byte 0 carries implemented bits
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctl_r <= '0;
        end else if (CE && wr_do && waddr_r == OFS_CONTROL && wstrb_r[0]) begin
            ctl_r.start                  <= wbits[CTL_START];
            ctl_r.descriptor_poll_enable <= wbits[CTL_POLL];
            ctl_r.transfer_dma_enable    <= wbits[CTL_DMA];
        end
    end

    // Interrupt mask, same layout as status
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mask_r <= IRQ_RESET;
        end else if (CE && wr_do && waddr_r == OFS_IRQ_MASK && wstrb_r[0]) begin
            mask_r <= wbits[IRQ_W-1:0];
        end
    end

    // ********************************************************************
    // Current descriptor address
    // ********************************************************************
    // loads only while running
    assign desc_load = ctl_r.start && DESC_ADDR_VALID;

    // tracks the fetch engine, zero at reset
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cur_addr_r <= ADDR_RESET;
        end else if (CE && desc_load) begin
            cur_addr_r <= DESC_ADDR;
        end
    end

    // ********************************************************************
    // Interrupt flags
    // ********************************************************************
    // Level conditions keep setting their flag while they hold
    // Bit order follows IRQ_DESC, IRQ_RX, IRQ_TX
    assign events = {desc_load, rx_int_r, tx_int_r};

    assign stat_we = wr_do && (waddr_r == OFS_IRQ_STAT) && wstrb_r[0];

    sticky_status u_status (
        .CLK      (CLK),
        .ARST_N   (ARST_N),
        .ce       (CE),
        .set_evt  (events),
        .clr_we   (stat_we),
        .clr_bits (wbits[IRQ_W-1:0]),
        .status   (status)
    );

    // One cycle behind the flags, but glitch free
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_r <= 1'b0;
        end else if (CE) begin
            irq_r <= |(status & mask_r);
        end
    end

    // ********************************************************************
    // Read channel
    // ********************************************************************
    // Unimplemented bits read zero
    always_comb begin
        rd_word   = '0;
        rd_mapped = 1'b1;
        unique case (S_AXI_ARADDR)
            OFS_THRESHOLD: begin
                rd_word[THR_TX_LSB +: THR_W] = thr_r.tx_space_threshold;
                rd_word[THR_RX_LSB +: THR_W] = thr_r.rx_fill_threshold;
            end
            OFS_CONTROL: begin
                rd_word[CTL_START] = ctl_r.start;
                rd_word[CTL_POLL]  = ctl_r.descriptor_poll_enable;
                rd_word[CTL_DMA]   = ctl_r.transfer_dma_enable;
            end
            OFS_CUR_ADDR: rd_word = cur_addr_r;
            OFS_IRQ_STAT: rd_word[IRQ_W-1:0] = status;
            OFS_IRQ_MASK: rd_word[IRQ_W-1:0] = mask_r;
            default:      rd_mapped = 1'b0;
        endcase
    end

    // Data captured with the address; answers a cycle later
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rresp_r   <= RESP_OKAY;
            rdata_r   <= '0;
        end else if (CE) begin
            if (S_AXI_ARVALID && arready_r) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rresp_r   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
                rdata_r   <= rd_word;
            end else if (rvalid_r && S_AXI_RREADY) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    assign S_AXI_AWREADY = awready_r;
    assign S_AXI_WREADY  = wready_r;
    assign S_AXI_BVALID  = bvalid_r;
    assign S_AXI_BRESP   = bresp_r;
    assign S_AXI_ARREADY = arready_r;
    assign S_AXI_RVALID  = rvalid_r;
    assign S_AXI_RRESP   = rresp_r;
    assign S_AXI_RDATA   = rdata_r;
    assign FETCH_ENABLE  = ctl_r.start;
    assign POLL_ENABLE   = ctl_r.descriptor_poll_enable;
    assign DMA_ENABLE    = ctl_r.transfer_dma_enable;
    assign TX_INT        = tx_int_r;
    assign RX_INT        = rx_int_r;
    assign IRQ           = irq_r;

endmodule
`default_nettype wire

// ===== design/qfdc_pkg.sv
// Function
// - TX condition when free space exceeds threshold
// - RX condition when fill reaches threshold
// - Threshold fields reset zero, spare bits zero
// - Control bit 2 starts descriptor processor
// - Control bit 1 enables descriptor polling
// - Control bit 0 enables DMA transfers
// - Control bits 31-3 read zero, ignore writes
// - Read-only current descriptor address, resets zero
package qfdc_pkg;

    // ********************************************************************
    // Widths
    // ********************************************************************
    localparam int unsigned ADDR_W      = 8;        // Byte address bits
    localparam int unsigned DATA_W      = 32;       // Bus data width
    localparam int unsigned THR_W       = 5;        // Threshold field width
    localparam int unsigned CNT_W       = 6;        // Holds counts 0..32
    localparam int unsigned IRQ_W       = 3;        // Interrupt events

    // ********************************************************************
    // Register offsets (byte addresses)
    // ********************************************************************
    localparam logic [ADDR_W-1:0] OFS_THRESHOLD = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CONTROL   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CUR_ADDR  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'h10;

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int unsigned THR_TX_LSB  = 8;        // Transmit threshold bits 12:8
    localparam int unsigned THR_RX_LSB  = 0;        // Receive threshold bits 4:0
    localparam int unsigned CTL_START   = 2;
    localparam int unsigned CTL_POLL    = 1;
    localparam int unsigned CTL_DMA     = 0;
    localparam int unsigned IRQ_TX      = 0;        // Transmit space event
    localparam int unsigned IRQ_RX      = 1;        // Receive fill event
    localparam int unsigned IRQ_DESC    = 2;        // Descriptor address loaded

    // ********************************************************************
    // Reset values and responses
    // ********************************************************************
    localparam logic [THR_W-1:0]  THR_RESET   = 5'h00;
    localparam logic [DATA_W-1:0] ADDR_RESET  = 32'h0000_0000;
    localparam logic [IRQ_W-1:0]  IRQ_RESET   = 3'h0;
    localparam logic [1:0]        RESP_OKAY   = 2'h0;
    localparam logic [1:0]        RESP_SLVERR = 2'h2;

    // ********************************************************************
    // Carriers
    // ********************************************************************
    typedef struct packed {
        logic [THR_W-1:0] tx_space_threshold;   // Free-space level for transmit
        logic [THR_W-1:0] rx_fill_threshold;    // Fill level for receive
    } threshold_t;

    typedef struct packed {
        logic start;                            // Descriptor processor running
        logic descriptor_poll_enable;           // Polling of descriptors
        logic transfer_dma_enable;              // DMA transfers allowed
    } control_t;

endpackage

// ===== design/level_compare.sv
`timescale 1ns/1ps
`default_nettype none
module level_compare
    import qfdc_pkg::*;
#(
    parameter bit STRICT = 1'b0                 // 1: count > level, 0: count >= level
) (
    input  wire logic [CNT_W-1:0] count,
    input  wire logic [THR_W-1:0] level,
    output logic                  hit
);

    // ********************************************************************
    // Comparison
    // ********************************************************************
    // Pure combinational so the caller sees it in the same cycle; level zero-extended
    assign hit = STRICT ? (count > {1'b0, level}) : (count >= {1'b0, level});

endmodule
`default_nettype wire

// ===== design/sticky_status.sv
`timescale 1ns/1ps
`default_nettype none
module sticky_status
    import qfdc_pkg::*;
(
    input  wire logic             CLK,
    input  wire logic             ARST_N,
    input  wire logic             ce,
    input  wire logic [IRQ_W-1:0] set_evt,      // Events, one bit each
    input  wire logic             clr_we,       // Write-one-to-clear strobe
    input  wire logic [IRQ_W-1:0] clr_bits,     // Bits written as one
    output logic      [IRQ_W-1:0] status
);

    // ********************************************************************
    // Sticky bits
    // ********************************************************************
    logic [IRQ_W-1:0] status_r;
    logic [IRQ_W-1:0] status_nxt;

    // A set in the clearing cycle survives so no event is lost
    assign status_nxt = (status_r & ~({IRQ_W{clr_we}} & clr_bits)) | set_evt;

    // Frozen while the clock enable is low
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            status_r <= IRQ_RESET;
        end else if (ce) begin
            status_r <= status_nxt;
        end
    end

    assign status = status_r;

endmodule
`default_nettype wire

// ===== dv/qfdc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module qfdc_checker
    import qfdc_pkg::*;
(
    input wire logic              CLK,
    input wire logic              ARST_N,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic              S_AXI_ARVALID,
    input wire logic              S_AXI_ARREADY,
    input wire logic              S_AXI_AWVALID,
    input wire logic              S_AXI_AWREADY,
    input wire logic              S_AXI_WVALID,
    input wire logic              S_AXI_WREADY,
    input wire logic              S_AXI_BVALID,
    input wire logic              S_AXI_RVALID,
    input wire logic [DATA_W-1:0] S_AXI_RDATA,
    input wire logic [CNT_W-1:0]  TX_FREE_COUNT,
    input wire logic [CNT_W-1:0]  RX_FILL_COUNT,
    input wire logic              TX_INT,
    input wire logic              RX_INT
);
    logic [ADDR_W-1:0] rd_addr_r;
    // Register of the read in flight
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rd_addr_r <= 8'h00;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rd_addr_r <= S_AXI_ARADDR;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    sequence s_wr_take;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence s_b_answer;
        !S_AXI_BVALID ##1 S_AXI_BVALID;
    endsequence
    property p_wr_ans; s_wr_take |=> s_b_answer; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("late bvalid");
    property p_b_block; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
    a_b_block: assert property (p_b_block) else $error("ready in B");
    property p_rd_ans; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("late rvalid");
    property p_tx_zero; TX_FREE_COUNT == 6'h00 |=> !TX_INT; endproperty
    a_tx_zero: assert property (p_tx_zero) else $error("tx flag set");
    property p_tx_full; TX_FREE_COUNT == 6'h20 |=> TX_INT; endproperty
    a_tx_full: assert property (p_tx_full) else $error("tx flag missing");
    property p_rx_full; RX_FILL_COUNT >= 6'h1F |=> RX_INT; endproperty
    a_rx_full: assert property (p_rx_full) else $error("rx flag missing");
    property p_thr_rsvd;
        S_AXI_RVALID && rd_addr_r == OFS_THRESHOLD |-> (S_AXI_RDATA & 32'hFFFF_E0E0) == 32'h0;
    endproperty
    a_thr_rsvd: assert property (p_thr_rsvd) else $error("thr spare set");
    property p_ctl_rsvd;
        S_AXI_RVALID && rd_addr_r == OFS_CONTROL |-> (S_AXI_RDATA & 32'hFFFF_FFF8) == 32'h0;
    endproperty
    a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("ctl spare set");
endmodule
bind quad_flash_descriptor_control qfdc_checker i_qfdc_checker (.*);
`default_nettype wire

// ===== dv/qfdc_fifo_model.sv
`timescale 1ns/1ps
`default_nettype none
module qfdc_fifo_model
    import qfdc_pkg::*;
#(
    parameter logic [DATA_W-1:0] BASE = 32'h1000_0000  // First descriptor address
) (
    input  wire logic              CLK,
    input  wire logic              ARST_N,
    input  wire logic [CNT_W-1:0]  tx_goal,
    input  wire logic [CNT_W-1:0]  rx_goal,
    input  wire logic              desc_go,
    output logic      [CNT_W-1:0]  tx_free,
    output logic      [CNT_W-1:0]  rx_fill,
    output logic      [DATA_W-1:0] desc_addr,
    output logic                   desc_valid
);
    logic [DATA_W-1:0] next_r;  // Address the engine issues next
    // One byte a cycle, so every level is crossed
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tx_free <= 6'h20;
            rx_fill <= 6'h00;
        end else begin
            tx_free <= tx_free + CNT_W'(tx_goal > tx_free) - CNT_W'(tx_goal < tx_free);
            rx_fill <= rx_fill + CNT_W'(rx_goal > rx_fill) - CNT_W'(rx_goal < rx_fill);
        end
    end
    // Idle address toggles so stale values never pass
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            next_r     <= BASE;
            desc_addr  <= ~BASE;
            desc_valid <= 1'b0;
        end else begin
            desc_valid <= desc_go;
            desc_addr  <= desc_go ? next_r : ~desc_addr;
            next_r     <= desc_go ? next_r + 32'h0000_0010 : next_r;
        end
    end
endmodule
`default_nettype wire

// ===== dv/quad_flash_descriptor_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module quad_flash_descriptor_control_test import qfdc_pkg::*;;
    localparam logic [DATA_W-1:0] BASE = 32'h1000_0000;  // Model's first address
    logic              CLK, ARST_N, CE, DESC_ADDR_VALID, desc_go;
    logic [ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [2:0]        S_AXI_AWPROT, S_AXI_ARPROT;
    logic [DATA_W-1:0] S_AXI_WDATA, S_AXI_RDATA, DESC_ADDR, d;
    logic [3:0]        S_AXI_WSTRB;
    logic [1:0]        S_AXI_BRESP, S_AXI_RRESP;
    logic              S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
    logic              S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
    logic              FETCH_ENABLE, POLL_ENABLE, DMA_ENABLE, TX_INT, RX_INT, IRQ;
    logic [CNT_W-1:0]  TX_FREE_COUNT, RX_FILL_COUNT, tx_goal, rx_goal;
    logic [THR_W-1:0]  tt, tr;
    int                failures, n_tests, seed;
    quad_flash_descriptor_control i_quad_flash_descriptor_control (.*);
    qfdc_fifo_model #(.BASE(BASE)) i_qfdc_fifo_model (
        .CLK(CLK), .ARST_N(ARST_N), .tx_goal(tx_goal), .rx_goal(rx_goal), .desc_go(desc_go),
        .tx_free(TX_FREE_COUNT), .rx_fill(RX_FILL_COUNT), .desc_addr(DESC_ADDR),
        .desc_valid(DESC_ADDR_VALID));
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // A wait that used up its bound ends the run
    task automatic tmo(input int n);
        if (n >= 60) begin
            failures++;
            complete_run();
        end
    endtask
    // Expected {tx, rx} flags for given levels
    function automatic logic [1:0] ints(input logic [5:0] tf, rf, input logic [4:0] ttx, trx);
        return {tf > 6'(ttx), rf >= 6'(trx)};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
        bit ad, wd, bd;
        int n;
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= v;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        for (n = 0; n < 60 && !bd; n++) begin
            @(posedge CLK);
            ad |= S_AXI_AWREADY;
            wd |= S_AXI_WREADY;
            if (ad) S_AXI_AWVALID <= 1'b0;
            if (wd) S_AXI_WVALID <= 1'b0;
            bd = ad && wd && S_AXI_BVALID;
        end
        tmo(n);
        cmp("bresp", 32'(e), 32'(S_AXI_BRESP));
        S_AXI_BREADY <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e);
        int n;
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge CLK);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
            if (S_AXI_RVALID) break;
        end
        tmo(n);
        cmp("rdata", x, S_AXI_RDATA);
        cmp("rresp", 32'(e), 32'(S_AXI_RRESP));
        S_AXI_RREADY <= 1'b0;
        @(posedge CLK);
    endtask
    // Wait for the FIFO goals, then let flags land
    task automatic settle();
        int n;
        for (n = 0; n < 60; n++) begin
            @(posedge CLK);
            if (TX_FREE_COUNT === tx_goal && RX_FILL_COUNT === rx_goal) break;
        end
        tmo(n);
        repeat (2) @(posedge CLK);
    endtask
    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    initial begin
        {failures, n_tests, seed} = {32'd0, 32'd0, 32'd1801};
        {ARST_N, CE, desc_go, S_AXI_AWPROT, S_AXI_ARPROT, S_AXI_WSTRB} = 13'h080F;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, tx_goal, rx_goal} = {48'h0, 6'h20, 6'h00};
        repeat (2) @(posedge CLK);
        ARST_N <= 1'b1;
        rd(OFS_THRESHOLD, 32'h0, RESP_OKAY);
        rd(OFS_CONTROL, 32'h0, RESP_OKAY);
        rd(OFS_CUR_ADDR, 32'h0, RESP_OKAY);
        cmp("ints", 32'h3, 32'({TX_INT, RX_INT}));
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            wr(OFS_CONTROL, {d[31:3], 3'(i)}, RESP_OKAY);
            rd(OFS_CONTROL, 32'(i), RESP_OKAY);
            cmp("en", 32'(i), 32'({FETCH_ENABLE, POLL_ENABLE, DMA_ENABLE}));
        end
        d = $random(seed);
        wr(OFS_THRESHOLD, d, RESP_OKAY);
        rd(OFS_THRESHOLD, d & 32'h0000_1F1F, RESP_OKAY);
        for (int i = 0; i < 24; i++) begin
            d = $random(seed);
            {tt, tr} = {d[3:0] | 4'h1, 1'b0, d[7:4] | 4'h1, 1'b0};
            wr(OFS_THRESHOLD, {19'h0, tt, 3'h0, tr}, RESP_OKAY);
            tx_goal <= 6'(tt) + 6'(i % 3);
            rx_goal <= 6'(tr) + 6'(i % 3) - 6'h01;
            settle();
            cmp("ints", 32'(ints(tx_goal, rx_goal, tt, tr)), 32'({TX_INT, RX_INT}));
        end
        wr(OFS_THRESHOLD, 32'h0000_1F1F, RESP_OKAY);
        {tx_goal, rx_goal} <= 12'h000;
        settle();
        wr(OFS_IRQ_STAT, 32'h7, RESP_OKAY);
        rd(OFS_IRQ_STAT, 32'h0, RESP_OKAY);
        rx_goal <= 6'h20;
        settle();
        cmp("ints", 32'h1, 32'({TX_INT, RX_INT}));
        rd(OFS_IRQ_STAT, 32'h2, RESP_OKAY);
        cmp("irq", 32'h0, 32'(IRQ));
        wr(OFS_IRQ_MASK, 32'h2, RESP_OKAY);
        cmp("irq", 32'h1, 32'(IRQ));
        rx_goal <= 6'h00;
        settle();
        cmp("irq", 32'h1, 32'(IRQ));
        wr(OFS_IRQ_STAT, 32'h2, RESP_OKAY);
        cmp("irq", 32'h0, 32'(IRQ));
        rd(OFS_IRQ_MASK, 32'h2, RESP_OKAY);
        for (int i = 0; i < 2; i++) begin
            wr(OFS_CONTROL, i ? 32'h0 : 32'h4, RESP_OKAY);
            desc_go <= 1'b1;
            @(posedge CLK);
            desc_go <= 1'b0;
            @(posedge CLK);
            rd(OFS_CUR_ADDR, BASE, RESP_OKAY);
        end
        rd(OFS_IRQ_STAT, 32'h4, RESP_OKAY);
        cmp("fetch", 32'h0, 32'(FETCH_ENABLE));
        wr(OFS_CUR_ADDR, 32'hFFFF_FFFF, RESP_SLVERR);
        rd(OFS_CUR_ADDR, BASE, RESP_OKAY);
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(8'h44, 32'hFFFF_FFFF, RESP_SLVERR);
        complete_run();
    end
endmodule
`default_nettype wire
